// ===== src/drmc_regbank.sv
// addressed register bank with calibrated output code
`timescale 1ns/1ps
`include "drmc_defines.svh"

module drmc_regbank
  import drmc_pkg::*;
#(
  parameter int unsigned WD_CYC0 =
    `DRMC_WD_P0_MS * (`DRMC_NS_PER_MS / `DRMC_CLK_NS),
  parameter int unsigned WD_CYC1 =
    `DRMC_WD_P1_MS * (`DRMC_NS_PER_MS / `DRMC_CLK_NS),
  parameter int unsigned WD_CYC2 =
    `DRMC_WD_P2_MS * (`DRMC_NS_PER_MS / `DRMC_CLK_NS),
  parameter int unsigned WD_CYC3 =
    `DRMC_WD_P3_MS * (`DRMC_NS_PER_MS / `DRMC_CLK_NS),
  parameter logic [2:0] PART_ID = 3'h5 // value is arbitrary
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire drmc_cmd_s cmd,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [15:0] out_code,
  output logic wdt_alarm
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  drmc_state_s st_reg;
  drmc_state_s st_next;
  drmc_regs_s regs_rst;
  logic [15:0] cal_code;
  logic [15:0] rd_word;
  logic [27:0] wd_limit;
  logic wd_hit;
  logic per_ok;
  logic cv_ok;
  logic wr_en;
  logic rd_en;

  assign wr_en = cmd_valid && !cmd.rd;
  assign rd_en = cmd_valid && cmd.rd;
  assign per_ok = st_reg.regs.chsel[`DRMC_CH_BIT];
  assign cv_ok = st_reg.regs.cvsel[`DRMC_DC_BIT];

  // ----------------------------------------------------------------
  // power-on defaults
  // ----------------------------------------------------------------
  always_comb
  begin
    regs_rst = '0;
    regs_rst.gain = `DRMC_RST_GAIN;
    regs_rst.status = `DRMC_RST_STAT;
    regs_rst.calen = `DRMC_RST_ZERO;
  end

  // ----------------------------------------------------------------
  // calibration path
  // ----------------------------------------------------------------
  drmc_cal u_cal (
    .code_in(st_reg.regs.code),
    .gain_in(st_reg.regs.gain),
    .offs_in(st_reg.regs.offs),
    .cal_en(st_reg.regs.calen[`DRMC_CALIBRATION_ENABLE_BIT_BIT]),
    .code_out(cal_code)
  );

  // ----------------------------------------------------------------
  // watchdog period select
  // ----------------------------------------------------------------
  always_comb
  begin
    case (st_reg.regs.chsel[`DRMC_WPD_LSB +: 2])
      2'h0: wd_limit = WD_CYC0[27:0];
      2'h1: wd_limit = WD_CYC1[27:0];
      2'h2: wd_limit = WD_CYC2[27:0];
      default: wd_limit = WD_CYC3[27:0];
    endcase
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_word = 16'h0000;
    if (cmd.addr == `DRMC_A_SRST)
      rd_word = {15'h0000, st_reg.regs.rst};
    else if (cmd.addr == `DRMC_A_RCFG)
      rd_word = st_reg.regs.rcfg;
    else if (cmd.addr == `DRMC_A_CHSEL)
      rd_word = st_reg.regs.chsel;
    else if (cmd.addr == `DRMC_A_OCFG && per_ok)
      rd_word = st_reg.regs.ocfg;
    else if (cmd.addr == `DRMC_A_CODE && per_ok)
      rd_word = st_reg.regs.code;
    else if (cmd.addr == `DRMC_A_CVSEL)
      rd_word = st_reg.regs.cvsel;
    else if (cmd.addr == `DRMC_A_CVCFG && cv_ok)
      rd_word = st_reg.regs.cvcfg;
    else if (cmd.addr == `DRMC_A_CALEN && per_ok)
      rd_word = st_reg.regs.calen;
    else if (cmd.addr == `DRMC_A_GAIN && per_ok)
      rd_word = st_reg.regs.gain;
    else if (cmd.addr == `DRMC_A_OFFS && per_ok)
      rd_word = st_reg.regs.offs;
    else if (cmd.addr == `DRMC_A_STAT)
      rd_word = st_reg.regs.status;
    else if (cmd.addr == `DRMC_A_FMASK)
      rd_word = st_reg.regs.fmask;
    else if (cmd.addr == `DRMC_A_FRESP)
      rd_word = st_reg.regs.fresp;
    else if (cmd.addr == `DRMC_A_FCODE && per_ok)
      rd_word = st_reg.regs.fcode;
    else if (cmd.addr == `DRMC_A_ID)
      rd_word = {13'h0000, PART_ID};
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.rsp_valid = 1'b0;
    wd_hit = 1'b0;
    // watchdog count
    if (!st_reg.regs.chsel[`DRMC_WEN_BIT])
    begin
      st_next.wd_cnt = 28'h0000000;
    end
    else if (st_reg.wd_cnt >= wd_limit - 28'h0000001)
    begin
      st_next.wd_cnt = 28'h0000000;
      wd_hit = 1'b1;
    end
    else
    begin
      st_next.wd_cnt = st_reg.wd_cnt + 28'h0000001;
    end
    // register writes, masks drop reserved bits
    if (wr_en)
    begin
      if (cmd.addr == `DRMC_A_SRST)
      begin
        st_next.regs.rst = cmd.data[`DRMC_RST_BIT];
      end
      else if (cmd.addr == `DRMC_A_RCFG)
      begin
        st_next.regs.rcfg = cmd.data & `DRMC_M_RCFG;
      end
      else if (cmd.addr == `DRMC_A_CHSEL)
      begin
        st_next.regs.chsel = cmd.data & `DRMC_M_CHSEL;
      end
      else if (cmd.addr == `DRMC_A_OCFG && per_ok)
      begin
        st_next.regs.ocfg = cmd.data;
      end
      else if (cmd.addr == `DRMC_A_CODE && per_ok)
      begin
        st_next.regs.code = cmd.data;
      end
      else if (cmd.addr == `DRMC_A_CVSEL)
      begin
        st_next.regs.cvsel = cmd.data & `DRMC_M_CVSEL;
      end
      else if (cmd.addr == `DRMC_A_CVCFG && cv_ok)
      begin
        st_next.regs.cvcfg = cmd.data & `DRMC_M_CVCFG;
      end
      else if (cmd.addr == `DRMC_A_CALEN && per_ok)
      begin
        st_next.regs.calen = cmd.data & `DRMC_M_CALEN;
      end
      else if (cmd.addr == `DRMC_A_GAIN && per_ok)
      begin
        st_next.regs.gain = cmd.data;
      end
      else if (cmd.addr == `DRMC_A_OFFS && per_ok)
      begin
        st_next.regs.offs = cmd.data;
      end
      else if (cmd.addr == `DRMC_A_STAT)
      begin
        st_next.regs.status =
          st_reg.regs.status & ~(cmd.data & `DRMC_M_STAT_W1C);
      end
      else if (cmd.addr == `DRMC_A_FMASK)
      begin
        st_next.regs.fmask = cmd.data & `DRMC_M_FMASK;
      end
      else if (cmd.addr == `DRMC_A_FRESP)
      begin
        st_next.regs.fresp = cmd.data & `DRMC_M_FRESP;
      end
      else if (cmd.addr == `DRMC_A_FCODE && per_ok)
      begin
        st_next.regs.fcode = cmd.data;
      end
      else if (cmd.addr == `DRMC_A_WDRST && cmd.data[`DRMC_RWD_BIT])
      begin
        st_next.wd_cnt = 28'h0000000;
        wd_hit = 1'b0;
      end
      // idle and reserved addresses fall through
    end
    // expiry sets the flag after a status write clear; a same-cycle restart cancels it
    if (wd_hit)
    begin
      st_next.regs.status[`DRMC_WDT_BIT] = 1'b1;
    end
    st_next.regs.status[`DRMC_UTGL_BIT] = st_next.regs.rcfg[`DRMC_UBT_BIT];
    // read answer
    if (rd_en)
    begin
      st_next.rsp_valid = 1'b1;
      st_next.rsp_data = rd_word;
    end
    // pending soft reset wins over register writes and the watchdog count; the power-off bit and a read answer are kept
    if (st_reg.regs.rst)
    begin
      st_next.regs = regs_rst;
      st_next.regs.rcfg[`DRMC_POC_BIT] =
        st_reg.regs.rcfg[`DRMC_POC_BIT];
      st_next.wd_cnt = 28'h0000000;
    end
    st_next.out_code = cal_code;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
      st_reg.regs.gain <= `DRMC_RST_GAIN;
      st_reg.regs.status <= `DRMC_RST_STAT;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rsp_valid = st_reg.rsp_valid;
  assign rsp_data = st_reg.rsp_data;
  assign out_code = st_reg.out_code;
  assign wdt_alarm = st_reg.regs.status[`DRMC_WDT_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_srst_wr;
    wr_en && cmd.addr == `DRMC_A_SRST && cmd.data[`DRMC_RST_BIT];
  endsequence

  sequence s_srst_done;
    st_reg.regs.rst ##1 !st_reg.regs.rst;
  endsequence

  property p_gain_por;
    $past(sys_rst) |-> st_reg.regs.gain == 16'h8000;
  endproperty
  a_gain_por: assert property (p_gain_por)
    else $error("gain word not unity after reset");

  property p_bypass;
    !st_reg.regs.calen[`DRMC_CALIBRATION_ENABLE_BIT_BIT] && !st_reg.regs.rst
      |=> out_code == $past(st_reg.regs.code);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("code changed while calibration off");

  property p_unity;
    st_reg.regs.calen[`DRMC_CALIBRATION_ENABLE_BIT_BIT] && st_reg.regs.gain == 16'h8000
      && st_reg.regs.offs == 16'h0000 && !st_reg.regs.rst
      |=> out_code == $past(st_reg.regs.code);
  endproperty
  a_unity: assert property (p_unity)
    else $error("unity calibration altered the code");

  property p_sat_low;
    st_reg.regs.calen[`DRMC_CALIBRATION_ENABLE_BIT_BIT] && st_reg.regs.offs == 16'h8000
      && st_reg.regs.code == 16'h0000 && !st_reg.regs.rst
      |=> out_code == 16'h0000;
  endproperty
  a_sat_low: assert property (p_sat_low)
    else $error("negative result not clamped to zero");

  property p_srst;
    s_srst_wr |=> s_srst_done ##0 (st_reg.regs.gain == 16'h8000
      && st_reg.regs.code == 16'h0000 && st_reg.regs.calen == 16'h0000);
  endproperty
  a_srst: assert property (p_srst)
    else $error("soft reset did not restore defaults");

  property p_poc_kept;
    st_reg.regs.rst |=> st_reg.regs.rcfg[`DRMC_POC_BIT]
      == $past(st_reg.regs.rcfg[`DRMC_POC_BIT]);
  endproperty
  a_poc_kept: assert property (p_poc_kept)
    else $error("soft reset changed power-off bit");

  property p_nop;
    wr_en && cmd.addr == `DRMC_A_NOP && !st_reg.regs.rst && !wd_hit
      |=> st_reg.regs == $past(st_reg.regs);
  endproperty
  a_nop: assert property (p_nop)
    else $error("idle command changed a register");

  property p_rsv_read;
    rd_en && (cmd.addr == 7'h0F || cmd.addr > `DRMC_A_ID)
      |=> rsp_valid && rsp_data == 16'h0000;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("reserved address read not zero");

  property p_gain_wr;
    wr_en && cmd.addr == `DRMC_A_GAIN && per_ok && !st_reg.regs.rst
      |=> st_reg.regs.gain == $past(cmd.data);
  endproperty
  a_gain_wr: assert property (p_gain_wr)
    else $error("gain word write lost");

  property p_calen_bits;
    rd_en && cmd.addr == `DRMC_A_CALEN |=> rsp_data[15:1] == 15'h0000;
  endproperty
  a_calen_bits: assert property (p_calen_bits)
    else $error("reserved enable bits read non-zero");

  property p_wd_restart;
    wr_en && cmd.addr == `DRMC_A_WDRST && cmd.data[`DRMC_RWD_BIT]
      |=> st_reg.wd_cnt == 28'h0000000;
  endproperty
  a_wd_restart: assert property (p_wd_restart)
    else $error("watchdog count not restarted");

endmodule : drmc_regbank

// ===== src/drmc_defines.svh
// constants for the converter register bank and calibration path
`ifndef DRMC_DEFINES_SVH
`define DRMC_DEFINES_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define DRMC_A_NOP 7'h00
`define DRMC_A_SRST 7'h01
`define DRMC_A_RCFG 7'h02
`define DRMC_A_CHSEL 7'h03
`define DRMC_A_OCFG 7'h04
`define DRMC_A_CODE 7'h05
`define DRMC_A_CVSEL 7'h06
`define DRMC_A_CVCFG 7'h07
`define DRMC_A_CALEN 7'h08
`define DRMC_A_GAIN 7'h09
`define DRMC_A_OFFS 7'h0A
`define DRMC_A_STAT 7'h0B
`define DRMC_A_FMASK 7'h0C
`define DRMC_A_FRESP 7'h0D
`define DRMC_A_FCODE 7'h0E
`define DRMC_A_WDRST 7'h10
`define DRMC_A_ID 7'h11

// ----------------------------------------------------------------
// writable bit masks
// ----------------------------------------------------------------
`define DRMC_M_SRST 16'h0001
`define DRMC_M_RCFG 16'h1E1F
`define DRMC_M_CHSEL 16'h023F
`define DRMC_M_FULL 16'hFFFF
`define DRMC_M_CVSEL 16'h0001
`define DRMC_M_CVCFG 16'h0FFF
`define DRMC_M_CALEN 16'h0001
`define DRMC_M_STAT_W1C 16'h0820
`define DRMC_M_FMASK 16'h0831
`define DRMC_M_FRESP 16'h00FF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DRMC_RST_BIT 0
`define DRMC_POC_BIT 1
`define DRMC_UBT_BIT 0
`define DRMC_WEN_BIT 0
`define DRMC_WPD_LSB 1
`define DRMC_CH_BIT 5
`define DRMC_DC_BIT 0
`define DRMC_CALIBRATION_ENABLE_BIT_BIT 0
`define DRMC_WDT_BIT 11
`define DRMC_UTGL_BIT 6
`define DRMC_RWD_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DRMC_RST_GAIN 16'h8000
`define DRMC_RST_STAT 16'h1000
`define DRMC_RST_ZERO 16'h0000

// ----------------------------------------------------------------
// calibration and timing
// ----------------------------------------------------------------
`define DRMC_GAIN_BIAS 17'h08000
`define DRMC_CODE_MAX 16'hFFFF
`define DRMC_CLK_NS 10
`define DRMC_WD_P0_MS 10
`define DRMC_WD_P1_MS 51
`define DRMC_WD_P2_MS 102
`define DRMC_WD_P3_MS 204
`define DRMC_NS_PER_MS 1000000

`endif

// ===== src/drmc_pkg.sv
// types shared by the register bank and calibration path
package drmc_pkg;

  // ----------------------------------------------------------------
  // command frame: read flag, address, data word
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic [6:0] addr;
    logic [15:0] data;
  } drmc_cmd_s;

  // ----------------------------------------------------------------
  // register contents
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rst;
    logic [15:0] rcfg;
    logic [15:0] chsel;
    logic [15:0] ocfg;
    logic [15:0] code;
    logic [15:0] cvsel;
    logic [15:0] cvcfg;
    logic [15:0] calen;
    logic [15:0] gain;
    logic [15:0] offs;
    logic [15:0] status;
    logic [15:0] fmask;
    logic [15:0] fresp;
    logic [15:0] fcode;
  } drmc_regs_s;

  // ----------------------------------------------------------------
  // whole state of the bank
  // ----------------------------------------------------------------
  typedef struct packed {
    drmc_regs_s regs;
    logic [27:0] wd_cnt;
    logic [15:0] rsp_data;
    logic rsp_valid;
    logic [15:0] out_code;
  } drmc_state_s;

endpackage : drmc_pkg

// ===== src/drmc_cal.sv
// gain and offset correction with saturation
`timescale 1ns/1ps
`include "drmc_defines.svh"

module drmc_cal
  import drmc_pkg::*;
(
  input wire logic [15:0] code_in,
  input wire logic [15:0] gain_in,
  input wire logic [15:0] offs_in,
  input wire logic cal_en,
  output logic [15:0] code_out
);

  logic [16:0] gain_f;
  logic [32:0] prod;
  logic [16:0] scaled;
  logic signed [18:0] sum;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  always_comb
  begin
    gain_f = {1'b0, gain_in} + `DRMC_GAIN_BIAS;
    prod = {17'h00000, code_in} * {16'h0000, gain_f};
    scaled = prod[32:16];
    sum = $signed({2'b00, scaled}) + $signed({{3{offs_in[15]}}, offs_in});
    if (!cal_en)
    begin
      code_out = code_in;
    end
    else if (sum < 0)
    begin
      code_out = 16'h0000;
    end
    else if (sum > $signed({3'b000, `DRMC_CODE_MAX}))
    begin
      code_out = `DRMC_CODE_MAX;
    end
    else
    begin
      code_out = sum[15:0];
    end
  end

endmodule : drmc_cal

// ===== bench/drmc_host.sv
// host model issuing command frames to the register bank
`timescale 1ns/1ps

module drmc_host
  import drmc_pkg::*;
(
  input wire logic mclk,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  output logic cmd_valid,
  output drmc_cmd_s cmd
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
  end

  // ----------------------------------------------------------------
  // one frame: read flag, address, data word
  // ----------------------------------------------------------------
  task automatic xfer(input logic r, input logic [6:0] a,
    input logic [15:0] d, output logic [15:0] q, output logic ok);
    int n;
    q = 16'h0000;
    ok = 1'b0;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd <= {r, a, d};
    @(posedge mclk);
    cmd_valid <= 1'b0;
    // idle lines show the inverse, never the last frame
    cmd <= ~{r, a, d};
    if (r)
    begin
      for (n = 0; n < 4 && !ok; n++)
      begin
        #1;
        if (rsp_valid === 1'b1)
        begin
          q = rsp_data;
          ok = 1'b1;
        end
        else
          @(posedge mclk);
      end
    end
  endtask : xfer
endmodule : drmc_host

// ===== bench/dac_register_map_calibration_tb_top.sv
// testbench for the register bank and calibration path
`timescale 1ns/1ps
`include "drmc_defines.svh"

module dac_register_map_calibration_tb_top;
  import drmc_pkg::*;
  logic mclk;
  logic sys_rst;
  logic cmd_valid;
  logic rsp_valid;
  logic wdt_alarm;
  drmc_cmd_s cmd;
  logic [15:0] rsp_data;
  logic [15:0] out_code;
  int failures = 0;
  int samples_checked = 0;

  drmc_regbank #(.WD_CYC0(20), .WD_CYC1(40), .WD_CYC2(60),
    .WD_CYC3(80)) uut (.mclk(mclk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .out_code(out_code), .wdt_alarm(wdt_alarm));
  drmc_host host (.mclk(mclk), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd(cmd));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic ok;
    host.xfer(1'b0, a, d, q, ok);
  endtask : wr

  task automatic rd(input string nm, input logic [6:0] a,
    input logic [15:0] e);
    logic [15:0] q;
    logic ok;
    host.xfer(1'b1, a, 16'h0000, q, ok);
    chk({nm, " answer"}, 16'h0001, {15'h0000, ok});
    chk(nm, e, q);
  endtask : rd

  task automatic sel();
    wr(`DRMC_A_CVSEL, 16'h0001);
    wr(`DRMC_A_CHSEL, 16'h0020);
  endtask : sel

  function automatic logic [15:0] cal_ref(input logic [15:0] c,
    input logic [15:0] g, input logic [15:0] o);
    logic [32:0] p;
    int s;
    p = c * (g + 33'h008000);
    s = int'(p[32:16]) + int'($signed(o));
    if (s < 0)
      s = 0;
    if (s > 65535)
      s = 65535;
    return s[15:0];
  endfunction : cal_ref

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    rd("gain unselected", `DRMC_A_GAIN, 16'h0000);
    sel();
    rd("gain reset", `DRMC_A_GAIN, 16'h8000);
    rd("offset reset", `DRMC_A_OFFS, 16'h0000);
    rd("cal enable reset", `DRMC_A_CALEN, 16'h0000);
    rd("status reset", `DRMC_A_STAT, 16'h1000);
    rd("part id", `DRMC_A_ID, 16'h0005);
    chk("out code reset", 16'h0000, out_code);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_regs();
    wr(`DRMC_A_GAIN, 16'h1234);
    rd("gain rw", `DRMC_A_GAIN, 16'h1234);
    wr(`DRMC_A_OFFS, 16'hFEDC);
    rd("offset rw", `DRMC_A_OFFS, 16'hFEDC);
    wr(`DRMC_A_CALEN, 16'hFFFF);
    rd("cal enable bits", `DRMC_A_CALEN, 16'h0001);
    wr(`DRMC_A_RCFG, 16'hFFFF);
    rd("reset config bits", `DRMC_A_RCFG, 16'h1E1F);
    wr(`DRMC_A_RCFG, 16'h0000);
    $display("test registers done");
  endtask : t_regs

  task automatic t_cal();
    logic [15:0] tc [7][3];
    int i;
    logic [15:0] e;
    tc = '{'{16'hFFFF, 16'h8000, 16'h0000},
      '{16'h8000, 16'h0000, 16'h0000}, '{16'h4000, 16'hFFFF, 16'h0000},
      '{16'hC000, 16'h0000, 16'h7FFF}, '{16'h0100, 16'h8000, 16'h8000},
      '{16'h0000, 16'h8000, 16'h0001}, '{16'hFFFF, 16'hFFFF, 16'hFFFF}};
    wr(`DRMC_A_CALEN, 16'h0000);
    wr(`DRMC_A_CODE, 16'h1234);
    repeat (3) @(posedge mclk);
    chk("bypass code", 16'h1234, out_code);
    wr(`DRMC_A_CALEN, 16'h0001);
    for (i = 0; i < 7; i++)
    begin
      wr(`DRMC_A_CODE, tc[i][0]);
      wr(`DRMC_A_GAIN, tc[i][1]);
      wr(`DRMC_A_OFFS, tc[i][2]);
      repeat (3) @(posedge mclk);
      e = cal_ref(tc[i][0], tc[i][1], tc[i][2]);
      chk("corrected code", e, out_code);
    end
    $display("test calibration done");
  endtask : t_cal

  task automatic t_idle();
    wr(`DRMC_A_GAIN, 16'hAAAA);
    wr(`DRMC_A_NOP, 16'h5555);
    wr(7'h0F, 16'h5555);
    wr(7'h12, 16'h5555);
    wr(7'h7F, 16'h5555);
    rd("gain kept", `DRMC_A_GAIN, 16'hAAAA);
    rd("idle read", `DRMC_A_NOP, 16'h0000);
    rd("reserved 0f", 7'h0F, 16'h0000);
    rd("reserved 12", 7'h12, 16'h0000);
    $display("test idle done");
  endtask : t_idle

  task automatic t_cfg();
    wr(`DRMC_A_OCFG, 16'hFFFF);
    rd("output config", `DRMC_A_OCFG, 16'hFFFF);
    wr(`DRMC_A_CVCFG, 16'hFFFF);
    rd("converter config", `DRMC_A_CVCFG, 16'h0FFF);
    wr(`DRMC_A_CVSEL, 16'h0000);
    rd("converter unselected", `DRMC_A_CVCFG, 16'h0000);
    wr(`DRMC_A_CVCFG, 16'h0000);
    wr(`DRMC_A_CVSEL, 16'h0001);
    rd("converter kept", `DRMC_A_CVCFG, 16'h0FFF);
    wr(`DRMC_A_FMASK, 16'hFFFF);
    rd("fault mask bits", `DRMC_A_FMASK, 16'h0831);
    wr(`DRMC_A_FRESP, 16'hFFFF);
    rd("fault response bits", `DRMC_A_FRESP, 16'h00FF);
    wr(`DRMC_A_FCODE, 16'hFFFF);
    rd("fault code", `DRMC_A_FCODE, 16'hFFFF);
    wr(`DRMC_A_RCFG, 16'h0001);
    wr(`DRMC_A_STAT, 16'hFFFF);
    rd("status mirror", `DRMC_A_STAT, 16'h1040);
    wr(`DRMC_A_RCFG, 16'h0000);
    rd("restart write only", `DRMC_A_WDRST, 16'h0000);
    $display("test configuration done");
  endtask : t_cfg

  task automatic t_wdog();
    logic [15:0] cfg [4];
    int per [4];
    int p;
    cfg = '{16'h0021, 16'h0023, 16'h0025, 16'h0027};
    per = '{20, 40, 60, 80};
    for (p = 0; p < 4; p++)
    begin
      wr(`DRMC_A_CHSEL, cfg[p]);
      repeat (3)
      begin
        repeat (per[p] - 8) @(posedge mclk);
        wr(`DRMC_A_WDRST, 16'h0001);
        #1;
        chk("no expiry", 16'h0000, {15'h0000, wdt_alarm});
      end
      repeat (per[p] - 1) @(posedge mclk);
      #1;
      chk("before expiry", 16'h0000, {15'h0000, wdt_alarm});
      @(posedge mclk);
      #1;
      chk("at expiry", 16'h0001, {15'h0000, wdt_alarm});
      wr(`DRMC_A_CHSEL, 16'h0020);
      wr(`DRMC_A_STAT, 16'h0800);
      rd("status cleared", `DRMC_A_STAT, 16'h1000);
      chk("alarm cleared", 16'h0000, {15'h0000, wdt_alarm});
    end
    $display("test watchdog done");
  endtask : t_wdog

  task automatic t_srst();
    wr(`DRMC_A_RCFG, 16'h0003);
    wr(`DRMC_A_GAIN, 16'h1111);
    wr(`DRMC_A_SRST, 16'h0001);
    repeat (3) @(posedge mclk);
    rd("reset bit", `DRMC_A_SRST, 16'h0000);
    rd("power off bit", `DRMC_A_RCFG, 16'h0002);
    rd("select reset", `DRMC_A_CHSEL, 16'h0000);
    sel();
    rd("gain after reset", `DRMC_A_GAIN, 16'h8000);
    rd("cal after reset", `DRMC_A_CALEN, 16'h0000);
    $display("test soft reset done");
  endtask : t_srst

  task automatic t_hwrst();
    wr(`DRMC_A_CALEN, 16'h0001);
    wr(`DRMC_A_OFFS, 16'h0100);
    repeat (2) @(posedge mclk);
    #1;
    chk("offset applied", 16'h0100, out_code);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk("out code hw reset", 16'h0000, out_code);
    chk("alarm hw reset", 16'h0000, {15'h0000, wdt_alarm});
    rd("select hw reset", `DRMC_A_CHSEL, 16'h0000);
    sel();
    rd("gain hw reset", `DRMC_A_GAIN, 16'h8000);
    rd("offset hw reset", `DRMC_A_OFFS, 16'h0000);
    rd("cal hw reset", `DRMC_A_CALEN, 16'h0000);
    $display("test hardware reset done");
  endtask : t_hwrst

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  initial
  begin
    #100000;
    failures++;
    test_done();
  end

  initial
  begin
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_defaults();
    t_regs();
    t_cal();
    t_idle();
    t_cfg();
    t_wdog();
    t_srst();
    t_hwrst();
    test_done();
  end
endmodule : dac_register_map_calibration_tb_top
